// ---- sls_host_model.sv ----
// Host model: AXI4-Lite master doing single-word register cycles.
// Assumes one caller at a time; it drives the request record only.
module sls_host_model (
  input  wire logic                  core_clk,
  output sls_pkg::sls_axi_req_t      axi_req,
  input  wire sls_pkg::sls_axi_rsp_t axi_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle bus from time zero
  initial axi_req = '0;

  // Answer expected for each write, oldest first
  logic [1:0] bq[$];

  // AW and W offered together, each dropped once taken; bready up until B
  task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] exp = sls_pkg::RESP_OKAY);
    bq.push_back(exp);
    @(posedge core_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= addr;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= data;
    axi_req.wstrb   <= 4'hF;
    axi_req.bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
  endtask

  // Read data is judged by the bench monitor at the rvalid edge
  task automatic rd(input logic [7:0] addr);
    @(posedge core_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= addr;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
  endtask
endmodule

// ---- sls_pkg.sv ----
// Package for the supply level sequencer: register map, field layouts,
// command codes, timing constants and the state records of both modules.
// Assumes a 50 MHz core clock and a 32-bit AXI4-Lite register bus.
package sls_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_TIME_NS  = 300000;  // One adjustment step, 300 us
  // Least time, so round up to whole cycles
  localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 16;

  // ****************************************************************
  // Bus widths and answers
  // ****************************************************************
  localparam int              ADDR_W      = 8;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;
  localparam logic [31:0]     RDATA_NONE  = 32'h0000_0000;

  // ****************************************************************
  // Register indices and byte addresses (byte address = 4 x index)
  // ****************************************************************
  localparam logic [7:0] IDX_BIAS   = 8'h0B;
  localparam logic [7:0] IDX_IRQ    = 8'h36;
  localparam logic [7:0] IDX_MASK   = 8'h3A;
  localparam logic [7:0] IDX_CMD    = 8'h3B;
  localparam logic [7:0] IDX_STATUS = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_BIAS   = ADDR_W'(IDX_BIAS * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ    = ADDR_W'(IDX_IRQ * 4);
  localparam logic [ADDR_W-1:0] ADDR_MASK   = ADDR_W'(IDX_MASK * 4);
  localparam logic [ADDR_W-1:0] ADDR_CMD    = ADDR_W'(IDX_CMD * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS * 4);

  // ****************************************************************
  // Direct commands and voltage codes (code 0 = 2.7 V, 7 = 3.4 V)
  // ****************************************************************
  localparam logic [7:0] CMD_AUTO    = 8'hA2;
  localparam logic [7:0] CMD_MANUAL  = 8'hA3;
  localparam logic [2:0] SEL_MIN     = 3'h0;
  localparam logic [2:0] SEL_MAX     = 3'h7;
  localparam logic [2:0] MAIN_SEL_RST = 3'h0;
  localparam logic [2:0] PA_SEL_RST   = 3'h0;

  // ****************************************************************
  // Register layouts
  // ****************************************************************
  typedef struct packed {
    logic [25:0] pad;
    logic [2:0]  pa_reg_voltage_sel;
    logic [2:0]  main_reg_voltage_sel;
  } sls_bias_t;

  typedef struct packed {
    logic [22:0] pad;
    logic [2:0]  pa_applied;
    logic [2:0]  main_applied;
    logic        rf_on;
    logic        auto_use;
    logic        running;
  } sls_stat_t;

  typedef struct packed {
    logic [30:0] pad;
    logic        cmd_done;
  } sls_irq_t;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } sls_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sls_axi_rsp_t;

  // ****************************************************************
  // State records
  // ****************************************************************
  localparam int SYNC_W = 2;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] level;
  } sls_sync_t;

  typedef struct packed {
    sls_axi_rsp_t      rsp;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [2:0]        main_manual;
    logic [2:0]        pa_manual;
    logic [2:0]        auto_sel;
    logic              running;
    logic              auto_use;
    logic [TIMER_W-1:0] timer;
    logic              irq_status;
    logic              irq_mask;
    logic [2:0]        main_out;
    logic [2:0]        pa_out;
    logic              rf_on;
    logic              irq;
  } sls_state_t;

  localparam sls_state_t STATE_RST = '{main_manual: MAIN_SEL_RST, main_out: MAIN_SEL_RST,
                                       pa_manual: PA_SEL_RST, pa_out: PA_SEL_RST, default: '0};

endpackage

// ---- sls_supply_sequencer.sv ----
// Supply level sequencer: manual regulator settings, automatic step-down
// adjustment, power-down via the enable pin, command-completion interrupt.
// Assumes an AXI4-Lite master on core_clk and async en/headroom pins.
//
// Contract
// - The main regulator code (2.7 V to 3.4 V in 0.1 V steps) comes from a 3-bit field.
// - The PA regulator code comes from its own 3-bit field in the same bias register.
// - In automatic mode the PA supply takes the lower of its manual code and the automatic result.
// - Command A2h starts the automatic supply level adjustment.
// - Command A3h, sent by the host, returns both regulators to the manual fields.
// - Adjustment begins at the 3.4 V code with the RF field switched on.
// - Each 300 us the code drops by one 100 mV step, never below 2.7 V.
// - Adjustment ends once supply headroom reaches 300 mV or the lowest code is reached.
// - At the end the RF field goes off and the command-completion flag is set.
// - With the enable pin low the block stays powered down and idle.
// - The block runs only while the enable pin is high.
// - A pending unmasked interrupt drives the interrupt pin high.
// - At power-up every configuration register holds its default value.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
module sls_supply_sequencer #(
  parameter int STEP_CYCLES = sls_pkg::STEP_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire sls_pkg::sls_axi_req_t axi_req,
  output sls_pkg::sls_axi_rsp_t      axi_rsp,
  input  wire logic                 en_pin,
  input  wire logic                 external_supply_headroom,
  output logic      [2:0]           main_reg_sel,
  output logic      [2:0]           pa_supply_output,
  output logic                      rf_field_on,
  output logic                      irq_pin
);

  localparam logic [sls_pkg::TIMER_W-1:0] STEP_LAST = sls_pkg::TIMER_W'(STEP_CYCLES - 1);

  sls_pkg::sls_state_t st_reg;
  sls_pkg::sls_state_t st_next;
  logic [1:0]          pins_sync;
  logic                en_now;
  logic                headroom_now;
  logic                start_cmd;
  logic                manual_cmd;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  sls_sync3 u_sync (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .pin_in    ({external_supply_headroom, en_pin}),
    .level_out (pins_sync)
  );

  assign en_now       = pins_sync[0];
  assign headroom_now = pins_sync[1];

  // ****************************************************************
  // Bus, registers and adjustment sequencer
  // ****************************************************************
  always_comb begin
    logic                aw_hs;
    logic                w_hs;
    logic                ar_hs;
    logic                wr_go;
    logic                irq_clr;
    logic                done_evt;
    sls_pkg::sls_bias_t  bias_w;
    sls_pkg::sls_bias_t  bias_r;
    sls_pkg::sls_stat_t  stat_r;
    sls_pkg::sls_irq_t   irq_r;
    // Hold by default; decode this cycle's handshakes
    st_next    = st_reg;
    aw_hs      = axi_req.awvalid & st_reg.rsp.awready;
    w_hs       = axi_req.wvalid & st_reg.rsp.wready;
    ar_hs      = axi_req.arvalid & st_reg.rsp.arready;
    wr_go      = 1'b0;
    irq_clr    = 1'b0;
    done_evt   = 1'b0;
    start_cmd  = 1'b0;
    manual_cmd = 1'b0;
    bias_w     = '0;
    bias_r     = '0;
    stat_r     = '0;
    irq_r      = '0;

    // Write address and data are taken in either order
    if (aw_hs) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (w_hs) begin
      st_next.w_got = 1'b1;
      st_next.wdata = axi_req.wdata;
      st_next.wstrb = axi_req.wstrb;
    end
    if (st_reg.rsp.bvalid && axi_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    wr_go = st_next.aw_got & st_next.w_got & ~st_reg.rsp.bvalid;

    // Register write effects; only byte lane 0 carries fields
    if (wr_go) begin
      st_next.aw_got     = 1'b0;
      st_next.w_got      = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = sls_pkg::RESP_OKAY;
      bias_w             = sls_pkg::sls_bias_t'(st_next.wdata);
      case (st_next.aw_addr)
        sls_pkg::ADDR_BIAS: begin
          if (st_next.wstrb[0]) begin
            st_next.main_manual = bias_w.main_reg_voltage_sel;
            st_next.pa_manual   = bias_w.pa_reg_voltage_sel;
          end
        end
        sls_pkg::ADDR_IRQ: begin
          irq_clr = st_next.wstrb[0] & st_next.wdata[0];
        end
        sls_pkg::ADDR_MASK: begin
          if (st_next.wstrb[0]) begin
            st_next.irq_mask = st_next.wdata[0];
          end
        end
        sls_pkg::ADDR_CMD: begin
          if (st_next.wstrb[0]) begin
            start_cmd  = (st_next.wdata[7:0] == sls_pkg::CMD_AUTO);
            manual_cmd = (st_next.wdata[7:0] == sls_pkg::CMD_MANUAL);
          end
        end
        sls_pkg::ADDR_STATUS: begin
          st_next.rsp.bresp = sls_pkg::RESP_OKAY;
        end
        default: begin
          st_next.rsp.bresp = sls_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Write channels reopen once the answer is taken
    st_next.rsp.awready = ~st_next.aw_got & ~st_next.rsp.bvalid;
    st_next.rsp.wready  = ~st_next.w_got & ~st_next.rsp.bvalid;

    // Read answer is registered, one edge after the address is taken
    if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    // Snapshot of every readable register
    if (ar_hs) begin
      bias_r.main_reg_voltage_sel = st_reg.main_manual;
      bias_r.pa_reg_voltage_sel   = st_reg.pa_manual;
      stat_r.running              = st_reg.running;
      stat_r.auto_use             = st_reg.auto_use;
      stat_r.rf_on                = st_reg.rf_on;
      stat_r.main_applied         = st_reg.main_out;
      stat_r.pa_applied           = st_reg.pa_out;
      irq_r.cmd_done              = st_reg.irq_status;
      st_next.rsp.rvalid          = 1'b1;
      st_next.rsp.rresp           = sls_pkg::RESP_OKAY;
      case (axi_req.araddr)
        sls_pkg::ADDR_BIAS:   st_next.rsp.rdata = bias_r;
        sls_pkg::ADDR_IRQ:    st_next.rsp.rdata = irq_r;
        sls_pkg::ADDR_MASK:   st_next.rsp.rdata = {31'h0000_0000, st_reg.irq_mask};
        sls_pkg::ADDR_STATUS: st_next.rsp.rdata = stat_r;
        sls_pkg::ADDR_CMD:    st_next.rsp.rdata = sls_pkg::RDATA_NONE;
        default: begin
          st_next.rsp.rdata = sls_pkg::RDATA_NONE;
          st_next.rsp.rresp = sls_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_next.rsp.arready = ~st_next.rsp.rvalid;

    // Sequencer; manual command aborts a running adjustment silently
    if (manual_cmd) begin
      st_next.running  = 1'b0;
      st_next.auto_use = 1'b0;
    end else if (st_reg.running) begin
      // Count the interval out, then step or finish
      if (st_reg.timer != '0) begin
        st_next.timer = st_reg.timer - 1'b1;
      end else if (headroom_now || st_reg.auto_sel == sls_pkg::SEL_MIN) begin
        st_next.running  = 1'b0;
        st_next.auto_use = 1'b1;
        done_evt         = 1'b1;
      end else begin
        st_next.auto_sel = st_reg.auto_sel - 1'b1;
        st_next.timer    = STEP_LAST;
      end
    end else if (start_cmd) begin
      st_next.running  = 1'b1;
      st_next.auto_sel = sls_pkg::SEL_MAX;
      st_next.timer    = STEP_LAST;
    end

    // Sticky completion flag; a new event beats a same-cycle clear
    st_next.irq_status = (st_reg.irq_status & ~irq_clr) | done_evt;

    // Outputs follow state by one edge so each is a plain flip-flop
    st_next.rf_on = st_reg.running;
    st_next.irq   = st_reg.irq_status & st_reg.irq_mask;
    if (st_reg.running || st_reg.auto_use) begin
      st_next.main_out = st_reg.auto_sel;
      // Lower code wins so the PA never sees more than either source
      if (st_reg.pa_manual < st_reg.auto_sel) begin
        st_next.pa_out = st_reg.pa_manual;
      end else begin
        st_next.pa_out = st_reg.auto_sel;
      end
    end else begin
      st_next.main_out = st_reg.main_manual;
      st_next.pa_out   = st_reg.pa_manual;
    end

    // Power-down: configuration back to defaults, nothing runs
    if (!en_now) begin
      st_next.main_manual = sls_pkg::MAIN_SEL_RST;
      st_next.pa_manual   = sls_pkg::PA_SEL_RST;
      st_next.running     = 1'b0;
      st_next.auto_use    = 1'b0;
      st_next.irq_status  = 1'b0;
      st_next.irq_mask    = 1'b0;
    end
  end

  // State register; the reset image holds every register default
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= sls_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp          = st_reg.rsp;
  assign main_reg_sel     = st_reg.main_out;
  assign pa_supply_output = st_reg.pa_out;
  assign rf_field_on      = st_reg.rf_on;
  assign irq_pin          = st_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_MAIN_MANUAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!st_reg.running && !st_reg.auto_use) |=> (main_reg_sel == $past(st_reg.main_manual)))
    else $error("main regulator code does not follow manual field");

  AST_PA_MANUAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!st_reg.running && !st_reg.auto_use) |=> (pa_supply_output == $past(st_reg.pa_manual)))
    else $error("PA regulator code does not follow its manual field");

  AST_PA_LOWEST: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.auto_use |=> (pa_supply_output <= $past(st_reg.pa_manual))
                        && (pa_supply_output <= $past(st_reg.auto_sel)))
    else $error("PA supply code is not the lower of manual and automatic");

  AST_START: assert property (@(posedge core_clk) disable iff (!arst_n)
    (en_now && start_cmd && !manual_cmd && !st_reg.running)
      |=> st_reg.running && (st_reg.auto_sel == sls_pkg::SEL_MAX) ##1 rf_field_on)
    else $error("start command did not begin adjustment at top code");

  AST_MANUAL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (manual_cmd) |=> (!st_reg.running && !st_reg.auto_use))
    else $error("manual command did not return to manual control");

  AST_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    (en_now && !manual_cmd && st_reg.running && st_reg.timer == '0 && !headroom_now
     && st_reg.auto_sel != sls_pkg::SEL_MIN)
      |=> (st_reg.auto_sel == $past(st_reg.auto_sel) - 3'h1) && (st_reg.timer == STEP_LAST))
    else $error("adjustment step not taken at end of interval");

  AST_FINISH: assert property (@(posedge core_clk) disable iff (!arst_n)
    (en_now && !manual_cmd && st_reg.running && st_reg.timer == '0
     && (headroom_now || st_reg.auto_sel == sls_pkg::SEL_MIN))
      |=> !st_reg.running && st_reg.irq_status ##1 !rf_field_on)
    else $error("adjustment did not finish with flag set and field off");

  AST_IRQ_PIN: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.irq_status && st_reg.irq_mask) |=> irq_pin)
    else $error("interrupt pin low while unmasked flag pending");

  AST_POWER_DOWN: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!en_now) |=> !st_reg.running && (st_reg.main_manual == sls_pkg::MAIN_SEL_RST) ##1 !rf_field_on)
    else $error("block not idle and at defaults while disabled");

  AST_NO_RESTART: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.running && start_cmd && st_reg.timer != '0 && en_now)
      |=> (st_reg.auto_sel == $past(st_reg.auto_sel)) && (st_reg.timer == $past(st_reg.timer) - 1'b1))
    else $error("repeated start disturbed a running adjustment");

  // No unmasked flag, no interrupt
  AST_IRQ_QUIET: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(st_reg.irq_status && st_reg.irq_mask) |=> !irq_pin)
    else $error("interrupt pin high without unmasked flag");

  // Field loads the supply all through the run
  AST_RF_RUN: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.running |=> rf_field_on)
    else $error("RF field off during adjustment");

  // Field drops once the run is over
  AST_RF_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_reg.running |=> !rf_field_on)
    else $error("RF field on while idle");

  // Floor code is never left downwards
  AST_FLOOR: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.running && st_reg.auto_sel == sls_pkg::SEL_MIN) |=> (st_reg.auto_sel == sls_pkg::SEL_MIN))
    else $error("code stepped below the floor");

  // Code only moves at the end of an interval
  AST_HOLD_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.running && st_reg.timer != '0) |=> (st_reg.auto_sel == $past(st_reg.auto_sel)))
    else $error("code changed inside an interval");

  // A run only starts while enabled
  AST_RUN_ENABLED: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(st_reg.running) |-> $past(en_now))
    else $error("adjustment started while disabled");

  // Flag only set by a finishing run
  AST_FLAG_SRC: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(st_reg.irq_status) |-> $past(st_reg.running))
    else $error("completion flag set with no run");

  // Power-down reloads mask, flag and PA field
  AST_PD_DEFAULTS: assert property (@(posedge core_clk) disable iff (!arst_n)
    !en_now |=> !st_reg.irq_mask && !st_reg.irq_status && (st_reg.pa_manual == sls_pkg::PA_SEL_RST))
    else $error("defaults not reloaded in power-down");

  // Running code drives the main regulator
  AST_RUN_CODE: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.running |=> (main_reg_sel == $past(st_reg.auto_sel)))
    else $error("main code does not follow the running code");

  // PA never above the running code
  AST_PA_RUN: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.running |=> (pa_supply_output <= $past(st_reg.auto_sel)))
    else $error("PA code above the running code");

endmodule

// ---- sls_supply_sequencer_tb.sv ----
// Bench for the supply level sequencer with a shortened step count.
// Assumes sls_pkg and the host model are compiled first.
module sls_supply_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 20;
  logic                  core_clk;
  logic                  arst_n;
  sls_pkg::sls_axi_req_t axi_req;
  sls_pkg::sls_axi_rsp_t axi_rsp;
  logic                  en_pin;
  logic                  headroom;
  logic [2:0]            main_reg_sel;
  logic [2:0]            pa_supply_output;
  logic                  rf_field_on;
  logic                  irq_pin;
  int                    err_count = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  logic [33:0]           exp_q[$];
  logic [31:0]           seed = 32'h4C77;

  sls_supply_sequencer #(.STEP_CYCLES(STEP)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .en_pin(en_pin), .external_supply_headroom(headroom), .main_reg_sel(main_reg_sel),
    .pa_supply_output(pa_supply_output), .rf_field_on(rf_field_on), .irq_pin(irq_pin));
  sls_host_model host (.core_clk(core_clk), .axi_req(axi_req), .axi_rsp(axi_rsp));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected read answer noted before the cycle goes out
  task automatic rd(input logic [7:0] addr, input logic [33:0] exp);
    exp_q.push_back(exp);
    host.rd(addr);
  endtask

  function automatic logic [33:0] ok(input logic [31:0] d);
    return {sls_pkg::RESP_OKAY, d};
  endfunction

  // ****************************************************************
  // Clock, monitor and timeout
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Oldest note against each read answer; a hang ends the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (axi_rsp.rvalid && axi_req.rready) begin
      if (exp_q.size() == 0) check("rd_extra", 34'h0, 34'h1);
      else check("rd_data", {axi_rsp.rresp, axi_rsp.rdata}, exp_q.pop_front());
    end
    // Each write answer against the host's oldest note
    if (axi_rsp.bvalid && axi_req.bready) check("bresp", axi_rsp.bresp, host.bq.pop_front());
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [2:0] m;
    logic [2:0] p;
    int         t0;
    int         n;
    arst_n   = 1'b0;
    en_pin   = 1'b0;
    headroom = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    // Powered down: write is dropped
    host.wr(sls_pkg::ADDR_BIAS, 32'h0000_002D);
    repeat (3) @(posedge core_clk);
    check("main_pd", main_reg_sel, sls_pkg::MAIN_SEL_RST);
    en_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(sls_pkg::ADDR_BIAS, ok(32'h0));
    rd(sls_pkg::ADDR_MASK, ok(32'h0));
    rd(sls_pkg::ADDR_IRQ, ok(32'h0));
    rd(8'h00, {sls_pkg::RESP_SLVERR, sls_pkg::RDATA_NONE});
    host.wr(8'h04, 32'h0000_003F, sls_pkg::RESP_SLVERR);
    // Random manual codes
    seed = xs(seed);
    m = seed[2:0] | 3'h1;  // Never the default, so the write shows
    p = seed[5:3];
    host.wr(sls_pkg::ADDR_BIAS, {26'h0, p, m});
    repeat (3) @(posedge core_clk);
    check("main_man", main_reg_sel, m);
    check("pa_man", pa_supply_output, p);
    rd(sls_pkg::ADDR_BIAS, ok({26'h0, p, m}));
    // Headroom already present: stops at first check
    host.wr(sls_pkg::ADDR_MASK, 32'h1);
    headroom <= 1'b1;
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_AUTO});
    repeat (2) @(posedge core_clk);
    check("main_start", main_reg_sel, sls_pkg::SEL_MAX);
    check("rf_start", rf_field_on, 1'b1);
    for (n = 0; n < 3 * STEP && irq_pin !== 1'b1; n++) @(posedge core_clk);
    check("irq_a", irq_pin, 1'b1);
    check("main_a", main_reg_sel, sls_pkg::SEL_MAX);
    check("rf_a", rf_field_on, 1'b0);
    check("pa_a", pa_supply_output, p);
    rd(sls_pkg::ADDR_STATUS, ok({23'h0, p, sls_pkg::SEL_MAX, 3'h2}));
    rd(sls_pkg::ADDR_IRQ, ok(32'h1));
    host.wr(sls_pkg::ADDR_IRQ, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq_clr", irq_pin, 1'b0);
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_MANUAL});
    repeat (3) @(posedge core_clk);
    check("main_back", main_reg_sel, m);
    check("pa_back", pa_supply_output, p);
    // No headroom, masked: full walk down, repeated start mid-run
    headroom <= 1'b0;
    host.wr(sls_pkg::ADDR_MASK, 32'h0);
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_AUTO});
    t0 = cyc;
    repeat (STEP + 10) @(posedge core_clk);
    check("main_step", main_reg_sel, 3'h6);
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_AUTO});
    for (n = 0; n < 15 * STEP && rf_field_on !== 1'b0; n++) @(posedge core_clk);
    check("walk_time", (cyc - t0 >= 8 * STEP - 10) && (cyc - t0 <= 8 * STEP + 15), 1'b1);
    check("main_floor", main_reg_sel, sls_pkg::SEL_MIN);
    check("pa_min", pa_supply_output, sls_pkg::SEL_MIN);
    check("irq_masked", irq_pin, 1'b0);
    rd(sls_pkg::ADDR_IRQ, ok(32'h1));
    host.wr(sls_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq_unmask", irq_pin, 1'b1);
    host.wr(sls_pkg::ADDR_IRQ, 32'h1);
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_MANUAL});
    // Enable pin dropped in mid-run
    host.wr(sls_pkg::ADDR_CMD, {24'h0, sls_pkg::CMD_AUTO});
    repeat (3) @(posedge core_clk);
    en_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("rf_pd", rf_field_on, 1'b0);
    check("main_pd2", main_reg_sel, sls_pkg::MAIN_SEL_RST);
    en_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(sls_pkg::ADDR_BIAS, ok(32'h0));
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule

// ---- sls_sync3.sv ----
// Three-stage synchroniser for the asynchronous pin inputs.
// Assumes inputs are quasi-static levels; a change is accepted only once
// the second and third stages agree, which filters single-sample glitches.
module sls_sync3 (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic [sls_pkg::SYNC_W-1:0] pin_in,
  output logic      [sls_pkg::SYNC_W-1:0] level_out
);

  sls_pkg::sls_sync_t st_reg;
  sls_pkg::sls_sync_t st_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // First stage feeds only the second stage
  always_comb begin
    st_next       = st_reg;
    st_next.s1    = pin_in;
    st_next.s2    = st_reg.s1;
    st_next.s3    = st_reg.s2;
    st_next.level = (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.level & (st_reg.s2 ^ st_reg.s3));
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule
